//--- omsc_ctrl.sv
/*
 * Mode switch sequencer: walks the core through entry to protected mode and
 * the return to real-address mode, one operation at a time, and gates NMI.
 * Assumes the core acknowledges each operation and software uses the
 * register port: one-cycle strobes, read data one cycle after the strobe.
 */
// Function
// R1: Reset leaves real mode, flags clear.
// R2: Protect enable is control register bit zero.
// R3: Task register load optional without tasks or levels.
// R4: Level changes need a task state segment.
// R5: Descriptors made not busy; core marks busy.
// R6: Task register load only in protected mode.
// R7: Task register loaded before first task switch.
// R8: Later task register updates by switches only.
// R9: Setting protect enable enters level zero.
// R10: Mask, load global table, set enable, branch.
// R11: Far branch right after write serializes.
// R12: Paging switch code from identity-mapped page.
// R13: Reload segments; null selectors for unused ones.
// R14: Nothing between control write and branch.
// R15: NMI gated during switch; interrupts masked.
// R16: Clearing protect enable returns to real.
// R17: Clear paging, write zero directory base.
// R18: Branch to 64K readable segment first.
// R19: Load data segments with real-mode descriptor.
// R20: Unreloaded segments keep cached attributes.
// R21: Interrupt table inside the 1-MByte range.
// R22: Real-mode far jump reloads code segment.
// R23: Return code in one identity-mapped page.
// R24: Reset fetch starts at top address.
// R25: Mode and level held in own registers.
`timescale 1ns/1ns
module omsc_ctrl
	import omsc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_core_ack,
	output logic o_op_valid,
	output omsc_pkg::omsc_op_t o_op,
	output logic [31:0] o_op_arg,
	input wire logic i_nmi_req,
	output logic o_nmi,
	output logic o_busy,
	output logic o_protected,
	output logic [1:0] o_current_privilege_level,
	output logic [31:0] o_reset_fetch
);
	// ************************************************************
	// Software registers.
	// ************************************************************
	logic [3:0] ctrl_q;
	logic [3:0] ctrl_d;
	logic [31:0] gdt_q;
	logic [31:0] gdt_d;
	logic [31:0] idt_q;
	logic [31:0] idt_d;
	logic [31:0] task_q;
	logic [31:0] task_d;
	logic [31:0] seg_q;
	logic [31:0] seg_d;
	logic [31:0] pdbr_q;
	logic [31:0] pdbr_d;
	logic [31:0] real_idt_q;
	logic [31:0] real_idt_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic err_q;
	logic err_d;

	// ************************************************************
	// Sequencer and mode state.
	// ************************************************************
	omsc_state_t state_q;
	omsc_state_t state_d;
	logic prot_q;
	logic prot_d;
	logic paging_q;
	logic paging_d;
	logic [1:0] cpl_q;
	logic [1:0] cpl_d;
	logic task_loaded_q;
	logic task_loaded_d;
	logic issued_q;
	logic issued_d;
	logic leave_q; // Set on the way back to real mode until protect enable clears.
	logic leave_d;
	logic start;
	omsc_op_t op;
	logic [31:0] arg;
	logic done;

	// Builds a control register zero image from the two flags.
	function automatic logic [31:0] omsc_cr0(input logic pe, input logic pg);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[OMSC_CR0_PE_BIT] = pe;
		v[OMSC_CR0_PG_BIT] = pg;
		return v;
	endfunction : omsc_cr0

	// Register writes and reads; unmapped addresses read as zero.
	always_comb begin
		ctrl_d = ctrl_q;
		gdt_d = gdt_q;
		idt_d = idt_q;
		task_d = task_q;
		seg_d = seg_q;
		pdbr_d = pdbr_q;
		real_idt_d = real_idt_q;
		rdata_d = 32'h0000_0000;
		if (i_wr) begin
			unique case (i_addr)
				OMSC_REG_CTRL: ctrl_d = i_wdata[3:0];
				OMSC_REG_GDT_BASE: gdt_d = i_wdata;
				OMSC_REG_IDT_BASE: idt_d = i_wdata;
				OMSC_REG_TASK_SEL: task_d = i_wdata;
				OMSC_REG_SEG_SEL: seg_d = i_wdata;
				OMSC_REG_PDBR: pdbr_d = i_wdata;
				OMSC_REG_REAL_IDT: real_idt_d = i_wdata;
				default: ctrl_d = ctrl_q;
			endcase
		end
		// Go bits stand for one cycle only, so a refused request is not retried.
		if (!(i_wr && i_addr == OMSC_REG_CTRL)) begin
			ctrl_d[OMSC_CTRL_GO_PROT] = 1'b0;
			ctrl_d[OMSC_CTRL_GO_REAL] = 1'b0;
		end
		if (i_rd) begin
			unique case (i_addr)
				OMSC_REG_CTRL: rdata_d = {28'h0, ctrl_q};
				OMSC_REG_STATUS: rdata_d = {26'h0, err_q, task_loaded_q, cpl_q,
					paging_q, prot_q};
				OMSC_REG_GDT_BASE: rdata_d = gdt_q;
				OMSC_REG_IDT_BASE: rdata_d = idt_q;
				OMSC_REG_TASK_SEL: rdata_d = task_q;
				OMSC_REG_SEG_SEL: rdata_d = seg_q;
				OMSC_REG_PDBR: rdata_d = pdbr_q;
				OMSC_REG_REAL_IDT: rdata_d = real_idt_q;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// Sequencer: one operation per state, advancing when the core accepts it.
	always_comb begin
		state_d = state_q;
		prot_d = prot_q;
		paging_d = paging_q;
		cpl_d = cpl_q;
		task_loaded_d = task_loaded_q;
		err_d = err_q;
		issued_d = issued_q;
		leave_d = leave_q;
		start = 1'b0;
		op = OMSC_OP_NONE;
		arg = 32'h0000_0000;
		if (i_wr && i_addr == OMSC_REG_STATUS) begin
			err_d = 1'b0;
		end
		unique case (state_q)
			OMSC_ST_IDLE: op = OMSC_OP_NONE;
			OMSC_ST_CLI: op = OMSC_OP_INT_DISABLE; // [R10] [R15]
			OMSC_ST_GDT: begin
				op = OMSC_OP_LOAD_GLOBAL_TABLE; // [R10]
				arg = gdt_q;
			end
			OMSC_ST_CR0: begin
				op = OMSC_OP_WRITE_CTRL_ZERO; // [R2] [R9] [R16]
				arg = omsc_cr0(!prot_q, !prot_q && ctrl_q[OMSC_CTRL_PAGING]);
			end
			OMSC_ST_JMP: op = OMSC_OP_FAR_BRANCH; // [R11] [R14] [R22]
			OMSC_ST_LTR: begin
				op = OMSC_OP_LOAD_TASK_REG; // [R6] [R7]
				arg = task_q;
			end
			OMSC_ST_SEG: begin
				op = OMSC_OP_LOAD_SEGMENTS; // [R13] [R19] [R20]
				arg = seg_q;
			end
			OMSC_ST_IDT: begin
				op = OMSC_OP_LOAD_INT_TABLE;
				arg = leave_q ? real_idt_q : idt_q; // [R21]
			end
			OMSC_ST_STI: op = OMSC_OP_INT_ENABLE; // [R15]
			OMSC_ST_PGOFF: begin
				op = OMSC_OP_WRITE_CTRL_ZERO; // [R17]
				arg = omsc_cr0(1'b1, 1'b0);
			end
			OMSC_ST_CR3: begin
				op = OMSC_OP_WRITE_PAGE_DIR; // [R17]
				arg = OMSC_PDBR_FLUSH;
			end
			OMSC_ST_REAL_CS: op = OMSC_OP_FAR_BRANCH; // [R18] [R23]
			default: op = OMSC_OP_NONE;
		endcase
		if (state_q != OMSC_ST_IDLE && !issued_q) begin
			start = 1'b1;
			issued_d = 1'b1;
		end
		if (done) begin
			issued_d = 1'b0;
			unique case (state_q)
				OMSC_ST_CLI: state_d = prot_q ?
					(paging_q ? OMSC_ST_PGOFF : OMSC_ST_REAL_CS) : OMSC_ST_GDT;
				OMSC_ST_GDT: state_d = OMSC_ST_CR0;
				OMSC_ST_CR0: begin
					// Mode changes on the retiring control write only. [R25]
					if (!prot_q) begin
						prot_d = 1'b1; // [R9]
						paging_d = ctrl_q[OMSC_CTRL_PAGING]; // [R12]
						cpl_d = OMSC_CPL_ENTRY; // [R9]
					end else begin
						prot_d = 1'b0; // [R16]
						leave_d = 1'b0;
						paging_d = 1'b0;
					end
					state_d = OMSC_ST_JMP; // [R14]
				end
				OMSC_ST_JMP: begin
					// Far branch retires; core is serialized. [R11]
					if (prot_q && ctrl_q[OMSC_CTRL_USE_TASK] && !task_loaded_q) begin
						state_d = OMSC_ST_LTR; // [R3] [R4]
					end else if (prot_q) begin
						state_d = OMSC_ST_SEG;
					end else begin
						state_d = OMSC_ST_STI; // [R22]
					end
				end
				OMSC_ST_LTR: begin
					task_loaded_d = 1'b1; // [R5] [R8]
					state_d = OMSC_ST_SEG;
				end
				OMSC_ST_SEG: state_d = OMSC_ST_IDT;
				OMSC_ST_IDT: state_d = leave_q ? OMSC_ST_CR0 : OMSC_ST_STI; // [R21]
				OMSC_ST_STI: state_d = OMSC_ST_IDLE;
				OMSC_ST_PGOFF: begin
					paging_d = 1'b0; // [R17]
					state_d = OMSC_ST_CR3;
				end
				OMSC_ST_CR3: state_d = OMSC_ST_REAL_CS;
				OMSC_ST_REAL_CS: state_d = OMSC_ST_SEG; // [R18] [R19]
				default: state_d = OMSC_ST_IDLE;
			endcase
		end
		if (state_q == OMSC_ST_IDLE) begin
			if (ctrl_q[OMSC_CTRL_GO_PROT] && !prot_q) begin
				state_d = OMSC_ST_CLI;
			end else if (ctrl_q[OMSC_CTRL_GO_REAL] && prot_q) begin
				state_d = OMSC_ST_CLI;
				leave_d = 1'b1; // [R19] [R21]
			end else if (ctrl_q[OMSC_CTRL_GO_PROT] || ctrl_q[OMSC_CTRL_GO_REAL]) begin
				err_d = 1'b1; // A request that does not change mode is refused.
			end
		end
	end

	// Register all state; reset leaves the core view in real mode. [R1]
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q <= 4'h0;
			gdt_q <= 32'h0000_0000;
			idt_q <= 32'h0000_0000;
			task_q <= 32'h0000_0000;
			seg_q <= 32'h0000_0000;
			pdbr_q <= 32'h0000_0000;
			real_idt_q <= 32'h0000_0000;
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
			state_q <= OMSC_ST_IDLE;
			prot_q <= 1'b0;
			paging_q <= 1'b0;
			cpl_q <= OMSC_CPL_ENTRY;
			task_loaded_q <= 1'b0;
			issued_q <= 1'b0;
			leave_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			gdt_q <= gdt_d;
			idt_q <= idt_d;
			task_q <= task_d;
			seg_q <= seg_d;
			pdbr_q <= pdbr_d;
			real_idt_q <= real_idt_d;
			rdata_q <= rdata_d;
			err_q <= err_d;
			state_q <= state_d;
			prot_q <= prot_d;
			paging_q <= paging_d;
			cpl_q <= cpl_d;
			task_loaded_q <= task_loaded_d;
			issued_q <= issued_d;
			leave_q <= leave_d;
		end
	end

	// ************************************************************
	// Operation issue and NMI gating.
	// ************************************************************
	omsc_op_issue u_issue (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_start(start),
		.i_op(op),
		.i_arg(arg),
		.i_core_ack(i_core_ack),
		.o_op_valid(o_op_valid),
		.o_op(o_op),
		.o_arg(o_op_arg),
		.o_done(done)
	);

	omsc_nmi_gate u_nmi (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_block(state_q != OMSC_ST_IDLE), // [R15]
		.i_nmi_req(i_nmi_req),
		.o_nmi(o_nmi)
	);

	assign o_rdata = rdata_q;
	assign o_busy = state_q != OMSC_ST_IDLE;
	assign o_protected = prot_q;
	assign o_current_privilege_level = cpl_q;
	assign o_reset_fetch = OMSC_RESET_FETCH; // [R24]
endmodule : omsc_ctrl

//--- omsc_pkg.sv
/*
 * Constants and types for the mode switch sequencer, which drives a core's
 * mode controls from outside through a plain operation port.
 * Assumes a single 250 MHz clock and an active-high asynchronous reset.
 */
package omsc_pkg;
	// ************************************************************
	// Operation codes issued to the core.
	// ************************************************************
	typedef enum logic [3:0] {
		OMSC_OP_NONE = 4'h0,
		OMSC_OP_INT_DISABLE = 4'h1,
		OMSC_OP_LOAD_GLOBAL_TABLE = 4'h2,
		OMSC_OP_WRITE_CTRL_ZERO = 4'h3,
		OMSC_OP_FAR_BRANCH = 4'h4,
		OMSC_OP_LOAD_TASK_REG = 4'h5,
		OMSC_OP_LOAD_SEGMENTS = 4'h6,
		OMSC_OP_LOAD_INT_TABLE = 4'h7,
		OMSC_OP_INT_ENABLE = 4'h8,
		OMSC_OP_WRITE_PAGE_DIR = 4'h9,
		OMSC_OP_LOAD_LOCAL_TABLE = 4'ha
	} omsc_op_t;

	// ************************************************************
	// Sequencer states.
	// ************************************************************
	typedef enum logic [3:0] {
		OMSC_ST_IDLE = 4'h0,
		OMSC_ST_CLI = 4'h1,
		OMSC_ST_GDT = 4'h2,
		OMSC_ST_CR0 = 4'h3,
		OMSC_ST_JMP = 4'h4,
		OMSC_ST_LTR = 4'h5,
		OMSC_ST_SEG = 4'h6,
		OMSC_ST_IDT = 4'h7,
		OMSC_ST_STI = 4'h8,
		OMSC_ST_PGOFF = 4'h9,
		OMSC_ST_CR3 = 4'ha,
		OMSC_ST_REAL_CS = 4'hb
	} omsc_state_t;

	// ************************************************************
	// Register map of the sequencer's own registers.
	// ************************************************************
	localparam logic [3:0] OMSC_REG_CTRL = 4'h0;
	localparam logic [3:0] OMSC_REG_STATUS = 4'h1;
	localparam logic [3:0] OMSC_REG_GDT_BASE = 4'h2;
	localparam logic [3:0] OMSC_REG_IDT_BASE = 4'h3;
	localparam logic [3:0] OMSC_REG_TASK_SEL = 4'h4;
	localparam logic [3:0] OMSC_REG_SEG_SEL = 4'h5;
	localparam logic [3:0] OMSC_REG_PDBR = 4'h6;
	localparam logic [3:0] OMSC_REG_REAL_IDT = 4'h7;

	// Control bit positions.
	localparam int OMSC_CTRL_GO_PROT = 0;
	localparam int OMSC_CTRL_GO_REAL = 1;
	localparam int OMSC_CTRL_PAGING = 2;
	localparam int OMSC_CTRL_USE_TASK = 3;

	// Control register zero fields.
	localparam int OMSC_CR0_PE_BIT = 0;
	localparam int OMSC_CR0_PG_BIT = 31;

	// Values fixed by the mode switch sequence.
	localparam logic [31:0] OMSC_PDBR_FLUSH = 32'h0000_0000;
	localparam logic [31:0] OMSC_RESET_FETCH = 32'hffff_fff0;
	localparam logic [31:0] OMSC_REAL_IDT_LIMIT = 32'h000f_ffff;
	localparam logic [1:0] OMSC_CPL_ENTRY = 2'h0;

	// Time that the NMI gate stays closed after a switch completes.
	localparam int OMSC_NMI_HOLD_NS = 8;
	localparam int OMSC_CLK_NS = 4;
	localparam int OMSC_NMI_HOLD_CYC = (OMSC_NMI_HOLD_NS + OMSC_CLK_NS - 1) / OMSC_CLK_NS;
endpackage : omsc_pkg

//--- omsc_op_issue.sv
/*
 * Operation issue stage: holds one operation toward the core until the core
 * accepts it, then reports completion.
 * Assumes the core raises i_core_ack for one cycle per accepted operation.
 */
`timescale 1ns/1ns
module omsc_op_issue
	import omsc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_start,
	input wire omsc_pkg::omsc_op_t i_op,
	input wire logic [31:0] i_arg,
	input wire logic i_core_ack,
	output logic o_op_valid,
	output omsc_pkg::omsc_op_t o_op,
	output logic [31:0] o_arg,
	output logic o_done
);
	logic busy_q;
	logic busy_d;
	omsc_op_t op_q;
	omsc_op_t op_d;
	logic [31:0] arg_q;
	logic [31:0] arg_d;

	// Latch a new operation and drop it once the core takes it.
	always_comb begin
		busy_d = busy_q;
		op_d = op_q;
		arg_d = arg_q;
		if (busy_q && i_core_ack) begin
			busy_d = 1'b0;
		end else if (!busy_q && i_start) begin
			busy_d = 1'b1;
			op_d = i_op;
			arg_d = i_arg;
		end
	end

	// Register the issue state.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_q <= 1'b0;
			op_q <= OMSC_OP_NONE;
			arg_q <= 32'h0000_0000;
		end else begin
			busy_q <= busy_d;
			op_q <= op_d;
			arg_q <= arg_d;
		end
	end

	assign o_op_valid = busy_q;
	assign o_op = op_q;
	assign o_arg = arg_q;
	assign o_done = busy_q && i_core_ack;
endmodule : omsc_op_issue

//--- omsc_nmi_gate.sv
/*
 * NMI gate: blocks the NMI request while a mode switch is in progress and
 * for a short hold afterwards.
 * Assumes the NMI request is synchronous to the core clock.
 */
`timescale 1ns/1ns
module omsc_nmi_gate
	import omsc_pkg::*;
#(
	parameter int HOLD_CYC = OMSC_NMI_HOLD_CYC
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_block,
	input wire logic i_nmi_req,
	output logic o_nmi
);
	logic [3:0] hold_q;
	logic [3:0] hold_d;
	logic open_q;
	logic open_d;

	// Close while blocked, then count down before opening again.
	always_comb begin
		hold_d = hold_q;
		open_d = open_q;
		if (i_block) begin
			hold_d = 4'(HOLD_CYC);
			open_d = 1'b0;
		end else if (hold_q != 4'h0) begin
			hold_d = hold_q - 4'h1;
		end else begin
			open_d = 1'b1;
		end
	end

	// Gate starts closed after reset and opens one cycle later while not blocked.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			hold_q <= 4'h0;
			open_q <= 1'b0;
		end else begin
			hold_q <= hold_d;
			open_q <= open_d;
		end
	end

	// Block at once while busy; the registered flag alone lags by one cycle.
	assign o_nmi = open_q && !i_block && i_nmi_req;
endmodule : omsc_nmi_gate

//--- omsc_ctrl_asserts.sv
/*
 * Checker for the mode switch sequencer, watching its ports only.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ns
module omsc_ctrl_chk
	import omsc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_core_ack,
	input wire logic o_op_valid,
	input wire omsc_pkg::omsc_op_t o_op,
	input wire logic [31:0] o_op_arg,
	input wire logic i_nmi_req,
	input wire logic o_nmi,
	input wire logic o_busy,
	input wire logic o_protected,
	input wire logic [1:0] o_current_privilege_level,
	input wire logic [31:0] o_reset_fetch
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// A pending operation holds still until the core takes it.
	op_hold_a: assert property (
		o_op_valid && !i_core_ack |=> o_op_valid && $stable(o_op) && $stable(o_op_arg))
		else $error("operation changed before ack");
	op_retire_a: assert property (
		o_op_valid && i_core_ack |=> !o_op_valid) else $error("valid held after ack");
	// Mode flag moves only when a control write retires.
	prot_enter_a: assert property (
		$rose(o_protected) |-> $past(i_core_ack && o_op_valid && o_op == OMSC_OP_WRITE_CTRL_ZERO
		&& o_op_arg[0]) && o_current_privilege_level == 2'h0) else $error("bad entry");
	prot_leave_a: assert property (
		$fell(o_protected) |-> $past(i_core_ack && o_op_valid && o_op == OMSC_OP_WRITE_CTRL_ZERO
		&& !o_op_arg[0])) else $error("bad return");
	// The far branch comes straight after a mode changing write.
	branch_next_a: assert property (
		i_core_ack && o_op_valid && o_op == OMSC_OP_WRITE_CTRL_ZERO && (!o_protected || !o_op_arg[0])
		|-> ##2 o_op_valid && o_op == OMSC_OP_FAR_BRANCH) else $error("no branch after write");
	dir_zero_a: assert property (
		o_op_valid && o_op == OMSC_OP_WRITE_PAGE_DIR |-> o_op_arg == 32'h0) else $error("dir not 0");
	nmi_gate_a: assert property (
		o_busy |-> !o_nmi) else $error("nmi passed while busy");
	mask_first_a: assert property (
		$rose(o_busy) |-> ##[1:2] o_op_valid && o_op == OMSC_OP_INT_DISABLE)
		else $error("sequence not opened by masking");
	fetch_addr_a: assert property (
		o_reset_fetch == 32'hffff_fff0) else $error("reset fetch wrong");
endmodule : omsc_ctrl_chk

bind omsc_ctrl omsc_ctrl_chk omsc_ctrl_chk_inst (.i_core_clk, .i_rst, .i_addr, .i_wdata,
	.i_wr, .i_rd, .o_rdata, .i_core_ack, .o_op_valid, .o_op, .o_op_arg, .i_nmi_req, .o_nmi,
	.o_busy, .o_protected, .o_current_privilege_level, .o_reset_fetch);

//--- omsc_core_model.sv
/*
 * Behavioural core that takes mode switch operations and tracks its flags.
 * Assumes the sequencer holds each operation until acknowledged.
 */
`timescale 1ns/1ns
module omsc_core_model
	import omsc_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_op_valid,
	input wire omsc_pkg::omsc_op_t i_op,
	input wire logic [31:0] i_arg,
	input wire logic [1:0] i_dly,
	output logic o_ack,
	output logic o_pe,
	output logic o_pg,
	output logic o_task_busy,
	output logic [1:0] o_cpl
);
	logic [1:0] cnt_q;
	logic [31:0] seg_q;
	logic [31:0] pdbr_q;
	// Accept after a variable wait; one pulse per operation.
	always @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_ack <= 1'b0;
			o_pe <= 1'b0;
			o_pg <= 1'b0;
			o_task_busy <= 1'b0;
			o_cpl <= 2'h0;
			cnt_q <= 2'h0;
			seg_q <= 32'h0;
			pdbr_q <= 32'h0;
		end else begin
			o_ack <= 1'b0;
			if (i_op_valid && !o_ack && cnt_q < i_dly) begin
				cnt_q <= cnt_q + 2'h1;
			end else if (i_op_valid && !o_ack) begin
				o_ack <= 1'b1;
				cnt_q <= 2'h0;
				case (i_op)
					OMSC_OP_WRITE_CTRL_ZERO: begin
						o_pe <= i_arg[0];
						o_pg <= i_arg[0] & i_arg[31];
						if (i_arg[0] && !o_pe) o_cpl <= 2'h0;
					end
					OMSC_OP_LOAD_TASK_REG: if (o_pe) o_task_busy <= 1'b1;
					OMSC_OP_LOAD_SEGMENTS: seg_q <= i_arg;
					OMSC_OP_WRITE_PAGE_DIR: pdbr_q <= i_arg;
					default: seg_q <= seg_q;
				endcase
			end
		end
	end
endmodule : omsc_core_model

//--- tb_omsc_ctrl.sv
/*
 * Self-checking bench for the mode switch sequencer with a core model.
 * Assumes the register map and operation order of the package.
 */
`timescale 1ns/1ns
module tb_omsc_ctrl;
	import omsc_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_nmi_req = 1'b0;
	logic rd_d = 1'b0;
	logic [3:0] i_addr = 4'h0;
	logic [31:0] i_wdata = 32'h0;
	logic [31:0] interrupt_descriptor_table, ridt, o_rdata, o_op_arg, o_reset_fetch;
	logic [1:0] dly = 2'h0;
	logic [1:0] lvl, current_privilege_level;
	logic ack, o_op_valid, o_nmi, o_busy, o_protected, pe, pg, tbusy;
	omsc_op_t o_op;
	logic [67:0] opq[$];
	logic [63:0] rdq[$];
	logic [67:0] oe;
	logic [63:0] re;
	int seed, checks = 0, error_cnt = 0, cyc = 0;
	always #2 i_core_clk = ~i_core_clk;
	omsc_ctrl omsc_ctrl_inst (.i_core_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_core_ack(ack), .o_op_valid, .o_op, .o_op_arg, .i_nmi_req, .o_nmi, .o_busy,
		.o_protected, .o_current_privilege_level(lvl), .o_reset_fetch);
	omsc_core_model omsc_core_model_inst (.i_core_clk, .i_rst, .i_op_valid(o_op_valid),
		.i_op(o_op), .i_arg(o_op_arg), .i_dly(dly), .o_ack(ack), .o_pe(pe), .o_pg(pg),
		.o_task_busy(tbusy), .o_cpl(current_privilege_level));
	task chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask : chk
	task test_done;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
		rdq.push_back({e, m});
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
	endtask : rd
	task p(input omsc_op_t o, input logic [31:0] a, input logic [31:0] m);
		opq.push_back({o, a, m});
	endtask : p
	task ent(input logic g, input logic t);
		p(OMSC_OP_INT_DISABLE, 32'h0, 32'h0);
		p(OMSC_OP_LOAD_GLOBAL_TABLE, 32'h0, 32'h0);
		p(OMSC_OP_WRITE_CTRL_ZERO, {g, 30'h0, 1'b1}, 32'h8000_0001);
		p(OMSC_OP_FAR_BRANCH, 32'h0, 32'h0);
		if (t) p(OMSC_OP_LOAD_TASK_REG, 32'h0, 32'h0);
		p(OMSC_OP_LOAD_SEGMENTS, 32'h0, 32'h0);
		p(OMSC_OP_LOAD_INT_TABLE, interrupt_descriptor_table, 32'hffff_ffff);
		p(OMSC_OP_INT_ENABLE, 32'h0, 32'h0);
	endtask : ent
	task ret;
		p(OMSC_OP_INT_DISABLE, 32'h0, 32'h0);
		p(OMSC_OP_WRITE_CTRL_ZERO, 32'h1, 32'h8000_0001);
		p(OMSC_OP_WRITE_PAGE_DIR, 32'h0, 32'hffff_ffff);
		p(OMSC_OP_FAR_BRANCH, 32'h0, 32'h0);
		p(OMSC_OP_LOAD_SEGMENTS, 32'h0, 32'h0);
		p(OMSC_OP_LOAD_INT_TABLE, ridt, 32'hffff_ffff);
		p(OMSC_OP_WRITE_CTRL_ZERO, 32'h0, 32'h0000_0001);
		p(OMSC_OP_FAR_BRANCH, 32'h0, 32'h0);
		p(OMSC_OP_INT_ENABLE, 32'h0, 32'h0);
	endtask : ret
	task run(input logic [31:0] c, input string n);
		wr(OMSC_REG_CTRL, c);
		repeat (3) @(posedge i_core_clk);
		for (int i = 0; i < 300 && o_busy !== 1'b0; i++) @(posedge i_core_clk);
		repeat (4) @(posedge i_core_clk);
		chk(opq.size() == 0, "operations missing");
		$display("test %s done", n);
	endtask : run
	// Compare read data and retired operations against the oldest notes.
	always @(posedge i_core_clk) begin
		rd_d <= i_rd;
		cyc++;
		if (rd_d) begin
			re = rdq.pop_front();
			chk((o_rdata & re[31:0]) === re[63:32], "read data");
		end
		if (o_op_valid && ack) begin
			oe = opq.pop_front();
			chk(o_op === omsc_op_t'(oe[67:64]) && (o_op_arg & oe[31:0]) === oe[63:32], "op");
			dly <= 2'($random(seed));
			i_nmi_req <= 1'($random(seed));
		end
		if (o_busy && i_nmi_req) chk(o_nmi === 1'b0, "nmi while busy");
		if (cyc == 20000) begin
			error_cnt++;
			test_done();
		end
	end
	// Main sequence: reset, entry, return, re-entry, refusal, gate.
	initial begin
		seed = 89;
		interrupt_descriptor_table = $random(seed);
		ridt = $random(seed) & 32'h000f_fff0;
		repeat (20) @(posedge i_core_clk);
		i_rst <= 1'b0;
		@(posedge i_core_clk);
		chk(o_protected === 1'b0 && lvl === 2'h0 && pe === 1'b0 && pg === 1'b0, "reset");
		chk(o_reset_fetch === 32'hffff_fff0, "fetch");
		rd(OMSC_REG_STATUS, 32'h0, 32'h3f);
		rd(4'hf, 32'h0, 32'hffff_ffff);
		wr(OMSC_REG_GDT_BASE, $random(seed));
		wr(OMSC_REG_IDT_BASE, interrupt_descriptor_table);
		wr(OMSC_REG_TASK_SEL, $random(seed));
		wr(OMSC_REG_SEG_SEL, $random(seed));
		wr(OMSC_REG_REAL_IDT, ridt);
		ent(1'b1, 1'b1);
		run(32'hd, "entry");
		rd(OMSC_REG_STATUS, 32'h13, 32'h3f);
		chk(o_protected === 1'b1 && lvl === 2'h0 && pe && pg && tbusy, "protected");
		ret();
		run(32'h2, "return");
		rd(OMSC_REG_STATUS, 32'h0, 32'h2f);
		chk(o_protected === 1'b0 && pe === 1'b0 && pg === 1'b0, "real");
		ent(1'b0, 1'b0);
		run(32'h9, "reentry");
		rd(OMSC_REG_STATUS, 32'h11, 32'h3f);
		run(32'h1, "refused");
		rd(OMSC_REG_STATUS, 32'h20, 32'h20);
		wr(OMSC_REG_STATUS, 32'h0);
		rd(OMSC_REG_STATUS, 32'h0, 32'h20);
		i_nmi_req <= 1'b1;
		repeat (4) @(posedge i_core_clk);
		chk(o_nmi === 1'b1, "nmi open");
		test_done();
	end
endmodule : tb_omsc_ctrl
